/* File: design/lcc_pkg.sv */
// constants for the common configuration register pair
package lcc_pkg;
   localparam int unsigned CMD_W = 16;
   localparam int unsigned REG_W = 48;
   localparam logic [15:0] CMD_WR_CFG0 = 16'hAA00;
   localparam logic [15:0] CMD_WR_CFG1 = 16'hAA01;
   localparam logic [15:0] CMD_RD_CFG0 = 16'hAA60;
   localparam logic [15:0] CMD_RD_CFG1 = 16'hAA61;
   localparam logic [15:0] CMD_SOFT_RST = 16'hAA80;
   // first register: reset, writable mask, fixed reserved value
   localparam logic [47:0] CFG0_RESET = 48'h1000_700F_0107;
   localparam logic [47:0] CFG0_MASK = 48'hCFF8_F8FF_F11F;
   localparam logic [47:0] CFG0_FIXED = 48'h1000_0000_0000;
   // second register
   localparam logic [47:0] CFG1_RESET = 48'h00E0_0094_A400;
   localparam logic [47:0] CFG1_MASK = 48'h7FFF_FFFF_FFFF;
   localparam logic [47:0] CFG1_FIXED = 48'h0000_0000_0000;
   // field positions in the first register
   localparam int unsigned DEV_CNT_LSB = 0;
   localparam int unsigned PREDIS_BIT = 8;
   localparam int unsigned PSAVE_BIT = 12;
   localparam int unsigned PSP_LSB = 13;
   localparam int unsigned OLR_BIT = 15;
   localparam int unsigned SCAN_LSB = 16;
   localparam int unsigned SUBP_LSB = 21;
   localparam int unsigned MRANGE_BIT = 27;
   localparam int unsigned MFACT_LSB = 28;
   localparam int unsigned RDLY_LSB = 35;
   localparam int unsigned GDLY_LSB = 38;
   localparam int unsigned BDLY_LSB = 41;
   localparam int unsigned STACK_LSB = 46;
   // frame structure
   localparam logic [4:0] SEG_LAST = 5'h1F;
   localparam logic [7:0] SUBP_STEP = 8'h10;
   typedef enum logic [1:0] {
      LCC_PSP_OFF = 2'b00,
      LCC_PSP_HIGH = 2'b01,
      LCC_PSP_MID = 2'b10,
      LCC_PSP_LOW = 2'b11
   } lcc_psp_t;
endpackage

/* File: design/lcc_regs.sv */
// common configuration register pair with frame segment sequencing
//
// Contract
// - device count field bits 4:0 means value plus one; resets 00111.
// - bit 8 enables pre-discharge; resets to one.
// - bit 12 enables power saving; resets to zero.
// - bits 14:13 pick saving level off/high/middle/low; reset 00.
// - bit 15 enables open-load effect removal; resets to zero.
// - scan lines bits 20:16 mean value plus one; reset 01111.
// - bits 23:21 give 16 times value plus one sub-periods; reset 000.
// - bit 27 picks multiplier range low 40-80 or high 80-160 MHz.
// - bits 31:28 set multiplier value plus one; reset 0111.
// - three 3-bit colour delays of 0 to 7 clocks, reset zero.
// - bits 47:46 pick stacking: 00/10 two, 01 single, 11 three.
// - frame splits into selected sub-periods, each into 32 segments.
`timescale 1ns/1ps
`default_nettype none
module lcc_regs (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // decoded command words from the serial front end
   input wire logic cmd_valid_in,
   input wire logic [lcc_pkg::CMD_W-1:0] cmd_id_in,
   input wire logic [lcc_pkg::REG_W-1:0] cmd_data_in,
   // read answer
   output logic rd_valid_out,
   output logic [lcc_pkg::REG_W-1:0] rd_data_out,
   // configuration fields
   output logic [lcc_pkg::REG_W-1:0] cfg0_out,
   output logic [lcc_pkg::REG_W-1:0] cfg1_out,
   output logic [5:0] device_count_out,
   output logic predischarge_enable_out,
   output logic power_save_enable_out,
   output logic [1:0] power_save_plus_level_out,
   output logic open_load_removal_enable_out,
   output logic [5:0] scan_lines_out,
   output logic [7:0] subperiod_count_out,
   output logic multiplier_range_out,
   output logic [4:0] multiplier_factor_out,
   output logic [2:0] red_group_delay_out,
   output logic [2:0] green_group_delay_out,
   output logic [2:0] blue_group_delay_out,
   output logic [1:0] stacking_size_out,
   // frame sequencing
   input wire logic segment_done_in,
   output logic [4:0] segment_index_out,
   output logic [6:0] subperiod_index_out
);
   import lcc_pkg::*;

   logic [47:0] cfg0_ff;
   logic [47:0] cfg1_ff;
   logic rd_valid_ff;
   logic [47:0] rd_data_ff;
   logic [5:0] dev_cnt_ff;
   logic [5:0] scan_ff;
   logic [7:0] subp_ff;
   logic [4:0] mfact_ff;
   logic [1:0] stack_ff;
   logic [4:0] seg_ff;
   logic [6:0] subp_idx_ff;

   function automatic logic [5:0] plus_one5(input logic [4:0] v);
      return {1'b0, v} + 6'h01;
   endfunction

   function automatic logic [7:0] subp_total(input logic [2:0] code);
      return SUBP_STEP * ({5'h00, code} + 8'h01);
   endfunction

   // devices in the stack: 0 and 2 mean two, 1 single, 3 three
   function automatic logic [1:0] stack_devs(input logic [1:0] code);
      logic [1:0] r;
      r = 2'h2;
      if (code == 2'b01) begin
         r = 2'h1;
      end else if (code == 2'b11) begin
         r = 2'h3;
      end
      return r;
   endfunction

   logic wr0;
   logic wr1;
   logic srst;
   assign wr0 = cmd_valid_in && (cmd_id_in == CMD_WR_CFG0);
   assign wr1 = cmd_valid_in && (cmd_id_in == CMD_WR_CFG1);
   assign srst = cmd_valid_in && (cmd_id_in == CMD_SOFT_RST);

   // masked writes keep reserved bits at their fixed pattern
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cfg0_ff <= CFG0_RESET;
      end else if (srst) begin
         cfg0_ff <= CFG0_RESET;
      end else if (wr0) begin
         cfg0_ff <= (cmd_data_in & CFG0_MASK) | CFG0_FIXED;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cfg1_ff <= CFG1_RESET;
      end else if (srst) begin
         cfg1_ff <= CFG1_RESET;
      end else if (wr1) begin
         cfg1_ff <= (cmd_data_in & CFG1_MASK) | CFG1_FIXED;
      end
   end

   // read answer one cycle after the command
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rd_valid_ff <= 1'b0;
         rd_data_ff <= 48'h0000_0000_0000;
      end else begin
         rd_valid_ff <= 1'b0;
         if (cmd_valid_in && cmd_id_in == CMD_RD_CFG0) begin
            rd_valid_ff <= 1'b1;
            rd_data_ff <= cfg0_ff;
         end else if (cmd_valid_in && cmd_id_in == CMD_RD_CFG1) begin
            rd_valid_ff <= 1'b1;
            rd_data_ff <= cfg1_ff;
         end
      end
   end

   // decoded counts lag the register by one cycle to keep outputs on flops
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         dev_cnt_ff <= 6'h08;
         scan_ff <= 6'h10;
         subp_ff <= 8'h10;
         mfact_ff <= 5'h08;
         stack_ff <= 2'h2;
      end else begin
         dev_cnt_ff <= plus_one5(cfg0_ff[DEV_CNT_LSB +: 5]);
         scan_ff <= plus_one5(cfg0_ff[SCAN_LSB +: 5]);
         subp_ff <= subp_total(cfg0_ff[SUBP_LSB +: 3]);
         mfact_ff <= 5'(cfg0_ff[MFACT_LSB +: 4]) + 5'h01;
         stack_ff <= stack_devs(cfg0_ff[STACK_LSB +: 2]);
      end
   end

   // segments wrap at 32; sub-periods wrap at the selected total
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         seg_ff <= 5'h00;
         subp_idx_ff <= 7'h00;
      end else if (segment_done_in) begin
         seg_ff <= seg_ff + 5'h01;
         if (seg_ff == SEG_LAST) begin
            if ({1'b0, subp_idx_ff} >= subp_ff - 8'h01) begin
               subp_idx_ff <= 7'h00;
            end else begin
               subp_idx_ff <= subp_idx_ff + 7'h01;
            end
         end
      end
   end

   assign rd_valid_out = rd_valid_ff;
   assign rd_data_out = rd_data_ff;
   assign cfg0_out = cfg0_ff;
   assign cfg1_out = cfg1_ff;
   assign device_count_out = dev_cnt_ff;
   assign predischarge_enable_out = cfg0_ff[PREDIS_BIT];
   assign power_save_enable_out = cfg0_ff[PSAVE_BIT];
   assign power_save_plus_level_out = cfg0_ff[PSP_LSB +: 2];
   assign open_load_removal_enable_out = cfg0_ff[OLR_BIT];
   assign scan_lines_out = scan_ff;
   assign subperiod_count_out = subp_ff;
   assign multiplier_range_out = cfg0_ff[MRANGE_BIT];
   assign multiplier_factor_out = mfact_ff;
   assign red_group_delay_out = cfg0_ff[RDLY_LSB +: 3];
   assign green_group_delay_out = cfg0_ff[GDLY_LSB +: 3];
   assign blue_group_delay_out = cfg0_ff[BDLY_LSB +: 3];
   assign stacking_size_out = cfg0_ff[STACK_LSB +: 2];
   assign segment_index_out = seg_ff;
   assign subperiod_index_out = subp_idx_ff;

   sequence wr0_seq;
      cmd_valid_in && cmd_id_in == CMD_WR_CFG0;
   endsequence

   sequence rd0_seq;
      cmd_valid_in && cmd_id_in == CMD_RD_CFG0;
   endsequence

   reserved_fixed_a: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      ((cfg0_ff & ~CFG0_MASK) == CFG0_FIXED) && cfg1_ff[47] == 1'b0)
      else $error("reserved bits changed");
   write_lands_a: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      wr0_seq |=> cfg0_ff == (($past(cmd_data_in) & CFG0_MASK) | CFG0_FIXED))
      else $error("write to first register not stored");
   read_answer_a: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      rd0_seq |=> rd_valid_out && rd_data_out == $past(cfg0_ff))
      else $error("read answer wrong");
   device_count_a: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      ##1 device_count_out == {1'b0, $past(cfg0_ff[4:0])} + 6'h01)
      else $error("device count decode wrong");
   scan_count_a: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      ##1 scan_lines_out == {1'b0, $past(cfg0_ff[20:16])} + 6'h01)
      else $error("scan line decode wrong");
   subperiod_total_a: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      ##1 subperiod_count_out ==
         8'h10 * ({5'h00, $past(cfg0_ff[23:21])} + 8'h01))
      else $error("sub-period total wrong");
   multiplier_a: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      ##1 multiplier_factor_out == {1'b0, $past(cfg0_ff[31:28])} + 5'h01)
      else $error("multiplier factor wrong");
   stacking_map_a: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      ##1 stack_ff == ($past(cfg0_ff[47:46]) == 2'b01 ? 2'h1 :
                       $past(cfg0_ff[47:46]) == 2'b11 ? 2'h3 : 2'h2))
      else $error("stacking decode wrong");
   segment_wrap_a: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      segment_done_in && seg_ff == 5'h1F |=> seg_ff == 5'h00)
      else $error("segment did not wrap at 32");
   subperiod_range_a: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      segment_done_in && seg_ff == 5'h1F &&
      {1'b0, subp_idx_ff} >= subp_ff - 8'h01
      |=> subp_idx_ff == 7'h00)
      else $error("sub-period did not wrap");
endmodule
`default_nettype wire

/* File: verification/lcc_host_model.sv */
// host controller model issuing command words to the register pair
`timescale 1ns/1ps
`default_nettype none
module lcc_host_model (
   // clock
   input wire logic clk_in,
   // command word lines
   output logic cmd_valid_out,
   output logic [15:0] cmd_id_out,
   output logic [47:0] cmd_data_out
);
   initial begin
      cmd_valid_out = 1'b0;
      cmd_id_out = 16'h0000;
      cmd_data_out = 48'h0;
   end
   // single-device stacking may not ask for more than sixteen lines
   function automatic logic [47:0] legal(input logic [47:0] d);
      legal = d;
      if (d[47:46] == 2'b01 && d[20] == 1'b1) begin
         legal[20:16] = 5'h0F;
      end
   endfunction
   task automatic send(input logic [15:0] id, input logic [47:0] d);
      @(posedge clk_in);
      cmd_valid_out <= 1'b1;
      cmd_id_out <= id;
      cmd_data_out <= d;
   endtask
   // idle lines keep moving so a stale word is never mistaken for data
   task automatic idle();
      @(posedge clk_in);
      cmd_valid_out <= 1'b0;
      cmd_id_out <= ~cmd_id_out;
      cmd_data_out <= ~cmd_data_out;
   endtask
endmodule
`default_nettype wire

/* File: verification/lcc_regs_tb.sv */
// self-checking bench for the common configuration register pair
`timescale 1ns/1ps
`default_nettype none
module lcc_regs_tb;
   import lcc_pkg::*;
   localparam logic [47:0] WM0 = 48'hCFF8_F8FF_F11F;
   localparam logic [47:0] RST0 = 48'h1000_700F_0107;
   localparam logic [47:0] RST1 = 48'h00E0_0094_A400;
   logic clk, rst_n, cv, sd, rv, mr, pd, ps, olr;
   logic [15:0] cid;
   logic [47:0] cd, rd, c0, c1, e0, e1, d;
   logic [5:0] dc, sl;
   logic [7:0] sc;
   logic [4:0] mf, si;
   logic [6:0] spi;
   logic [2:0] rg, gg, bg;
   logic [1:0] pl, st;
   logic [47:0] q[$];
   logic [31:0] rs;
   int n_fail, checked, cyc;
   lcc_host_model i_host (.clk_in(clk), .cmd_valid_out(cv),
      .cmd_id_out(cid), .cmd_data_out(cd));
   lcc_regs i_dut (.clk_in(clk), .rst_n_in(rst_n), .cmd_valid_in(cv),
      .cmd_id_in(cid), .cmd_data_in(cd), .rd_valid_out(rv),
      .rd_data_out(rd), .cfg0_out(c0), .cfg1_out(c1),
      .device_count_out(dc), .predischarge_enable_out(pd),
      .power_save_enable_out(ps), .power_save_plus_level_out(pl),
      .open_load_removal_enable_out(olr), .scan_lines_out(sl),
      .subperiod_count_out(sc), .multiplier_range_out(mr),
      .multiplier_factor_out(mf), .red_group_delay_out(rg),
      .green_group_delay_out(gg), .blue_group_delay_out(bg),
      .stacking_size_out(st), .segment_done_in(sd),
      .segment_index_out(si), .subperiod_index_out(spi));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction
   task automatic chk(input string nm, input logic [47:0] s,
                      input logic [47:0] e);
      checked++;
      if (s !== e) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic report_and_stop();
      $display("checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // reads queue their expectation; the watcher below compares answers
   task automatic rd_both();
      i_host.send(CMD_RD_CFG0, 48'h0);
      q.push_back(e0);
      i_host.send(CMD_RD_CFG1, 48'h0);
      q.push_back(e1);
      i_host.idle();
      repeat (3) @(posedge clk);
      #1;
   endtask
   task automatic fields();
      chk("dev", dc, e0[4:0] + 6'h01);
      chk("pdc", pd, e0[8]);
      chk("ps", ps, e0[12]);
      chk("psp", pl, e0[14:13]);
      chk("olr", olr, e0[15]);
      chk("scan", sl, e0[20:16] + 6'h01);
      chk("subp", sc, {e0[23:21] + 4'h1, 4'h0});
      chk("mrange", mr, e0[27]);
      chk("mfact", mf, e0[31:28] + 5'h01);
      chk("dly", {rg, gg, bg}, {e0[37:35], e0[40:38], e0[43:41]});
      chk("stack", st, e0[47:46]);
      chk("cfg0", c0, e0);
      chk("cfg1", c1, e1);
   endtask
   always @(posedge clk) begin
      if (rv === 1'b1) begin
         if (q.size() == 0) chk("spurious read", 48'h1, 48'h0);
         else chk("rd_data", rd, q.pop_front());
      end
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         report_and_stop();
      end
   end
   initial begin
      rst_n = 1'b0;
      sd = 1'b0;
      rs = 32'hF684799C;
      e0 = RST0;
      e1 = RST1;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      rd_both();
      fields();
      for (int i = 0; i < 12; i++) begin
         rs = xs(rs);
         d[31:0] = rs;
         rs = xs(rs);
         d[47:32] = rs[15:0];
         if (i == 0) d = 48'hFFFF_FFFF_FFFF;
         if (i == 1) d = 48'h0;
         if (i == 2) d = 48'h7FFF_FFFF_FFFF;
         d = i_host.legal(d);
         e0 = (d & WM0) | 48'h1000_0000_0000;
         e1 = {1'b0, ~d[46:0]};
         i_host.send(CMD_WR_CFG0, d);
         i_host.send(CMD_WR_CFG1, ~d);
         i_host.send(16'hAA02, ~d);
         rd_both();
         fields();
      end
      i_host.send(CMD_SOFT_RST, 48'h0);
      e0 = RST0;
      e1 = RST1;
      rd_both();
      fields();
      for (int i = 1; i <= 512; i++) begin
         @(posedge clk);
         sd <= 1'b1;
         if (i == 32 || i == 512) begin
            @(posedge clk);
            sd <= 1'b0;
            @(posedge clk);
            #1;
            chk("seg", si, 5'h00);
            chk("subp_idx", spi, (i == 32) ? 7'h01 : 7'h00);
         end
      end
      @(posedge clk);
      sd <= 1'b0;
      chk("queue empty", q.size(), 0);
      report_and_stop();
   end
endmodule
`default_nettype wire
